// [verilog/smc_pkg.sv]
// package for the supply margin controller: command codes, config field
// layout, channel counts and timing constants.
// assumes a single 100 MHz clock domain.
package smc_pkg;
    localparam int          CLK_HZ            = 100_000_000;
    localparam int          NUM_CH            = 12;
    localparam int          NUM_PWM           = 8;
    localparam int          NUM_DAC           = 4;
    localparam int          VOUT_W            = 16;
    localparam int          AVG_SAMPLES       = 4;
    localparam int          AVG_SHIFT         = 2;
    localparam int          SUM_W             = VOUT_W + AVG_SHIFT;
    // command code of the margining configuration register
    localparam logic [7:0]  CMD_MARGIN_CONFIG = 8'hdf;
    // field positions
    localparam int          CFG_SLOPE_BIT     = 15;
    localparam int          CFG_FIXED_BIT     = 14;
    localparam int          CFG_RSVD_HI       = 13;
    localparam int          CFG_RSVD_LO       = 8;
    localparam logic [15:0] CFG_RW_MASK       = 16'hc0ff;
    localparam logic [15:0] CFG_RESET         = 16'h0000;
    localparam logic [7:0]  DAC_AUTO_LEVEL    = 8'h00;
    localparam logic [7:0]  LEVEL_MAX         = 8'hff;
    localparam logic [7:0]  LEVEL_MIN         = 8'h00;
    // timing
    localparam int          PWM_FREQ_HZ_X10   = 3_125_000;
    localparam int          PWM_PERIOD_CYC    = (CLK_HZ / PWM_FREQ_HZ_X10) * 10;
    localparam int          STEP_MS           = 20;
    localparam int          STEP_CYC          = STEP_MS * (CLK_HZ / 1000);
    localparam int          SETTLE_MS         = 100;
    localparam int          SETTLE_CYC        = SETTLE_MS * (CLK_HZ / 1000);
    localparam int          TMR_W             = 24;

    typedef struct packed {
        logic       slope;
        logic       fixed_level;
        logic [5:0] rsvd;
        logic [7:0] initial_drive_level;
    } smc_cfg_t;

    typedef struct packed {
        logic       enable;
        logic       source;
        logic [7:0] level;
    } smc_dac_drive_t;
endpackage

// [verilog/smc_margin_ctrl.sv]
// margin controller for twelve supply channels: eight filtered pwm trims
// and four current dac outputs, with per-page configuration and faults.
// assumes the selected margin target per channel, the pg-all level and
// adc samples come from the surrounding device on MCLK.
// Behaviour
// R1: slope bit sets whether raising drive raises or lowers voltage; the code applies it on dac pages only.
// R2: fixed-level bit holds drive at initial level during margining.
// R3: config bits 13 to 8 always read zero.
// R4: initial drive level starts pwm margining and sets fixed level.
// R5: pages 8 to 11 drive current dac outputs 0 to 3.
// R6: margin-off under ignore-faults inhibits fault monitoring 100ms.
// R7: first step overshooting the target flags a margin fault.
// R8: drive at zero or full scale short of target flags fault.
// R9: loop keeps running on a supply after a margin fault.
// R10: fault sets summary, per-page flags and alert if enabled.
// R11: failed dac transfer surfaces as full-scale fault.
// R12: dac channels force initial drive level to zero.
// R13: host programs pwm level as 255 times feedback over supply.
// R14: margin high sinks current, margin low sources current.
// R15: margining starts only after all monitored channels are power good.
// R16: four samples averaged per 20ms, then one step.
// R17: margin outputs are high impedance when not margining.
// R18: pwm trims run at 312.5kHz.
// R19: stepping saturates at zero and full scale, never wraps.
`timescale 1ns/1ps
`default_nettype none
module smc_margin_ctrl
    import smc_pkg::*;
#(
    parameter int STEP_CYCLES   = smc_pkg::STEP_CYC,
    parameter int SETTLE_CYCLES = smc_pkg::SETTLE_CYC
) (
    input  wire logic                        MCLK,
    input  wire logic                        RESET,
    input  wire logic                        CMD_WR,
    input  wire logic                        CMD_RD,
    input  wire logic [3:0]                  CMD_PAGE,
    input  wire logic [7:0]                  CMD_CODE,
    input  wire logic [15:0]                 CMD_WDATA,
    output logic      [15:0]                 CMD_RDATA,
    output logic                             CMD_RVALID,
    input  wire logic [smc_pkg::NUM_CH-1:0]  MARGIN_HIGH,
    input  wire logic [smc_pkg::NUM_CH-1:0]  MARGIN_LOW,
    input  wire logic [smc_pkg::NUM_CH-1:0]  IGNORE_FAULTS,
    input  wire logic                        PG_ALL,
    input  wire logic [smc_pkg::VOUT_W-1:0]  VOUT_TARGET [smc_pkg::NUM_CH],
    input  wire logic                        ADC_VALID,
    input  wire logic [3:0]                  ADC_CH,
    input  wire logic [smc_pkg::VOUT_W-1:0]  ADC_DATA,
    input  wire logic                        ALERT_EN,
    input  wire logic                        CLEAR_FAULTS,
    output logic [smc_pkg::NUM_PWM-1:0]      TRIM_PWM_OUT,
    output logic [smc_pkg::NUM_PWM-1:0]      TRIM_PWM_OE_N,
    output smc_pkg::smc_dac_drive_t          CURRENT_DAC_OUT [smc_pkg::NUM_DAC],
    output logic [smc_pkg::NUM_CH-1:0]       MARGIN_FAULT,
    output logic                             STATUS_MARGIN,
    output logic                             ALERT,
    output logic [smc_pkg::NUM_CH-1:0]       FAULT_MON_INHIBIT
);
    import smc_pkg::*;

    // pwm duty threshold in period cycles for an 8-bit drive level
    function automatic logic [8:0] duty_thresh(input logic [7:0] lvl);
        logic [16:0] prod;
        prod = 17'(lvl) * 17'(PWM_PERIOD_CYC);
        return prod[16:8];
    endfunction

    // true when a larger setting gives a higher output voltage
    function automatic logic inc_raises(input logic slope, input logic is_dac);
        return is_dac ? slope : 1'b0;
    endfunction

    smc_cfg_t          cfg_r      [NUM_CH];
    smc_cfg_t          cfg_nxt    [NUM_CH];
    logic [7:0]        set_r      [NUM_CH];
    logic [7:0]        set_nxt    [NUM_CH];
    logic [SUM_W-1:0]  sum_r      [NUM_CH];
    logic [SUM_W-1:0]  sum_nxt    [NUM_CH];
    logic [2:0]        cnt_r      [NUM_CH];
    logic [2:0]        cnt_nxt    [NUM_CH];
    logic [TMR_W-1:0]  settle_r   [NUM_CH];
    logic [TMR_W-1:0]  settle_nxt [NUM_CH];
    logic [NUM_CH-1:0] active_r,  active_nxt;
    logic [NUM_CH-1:0] first_r,   first_nxt;
    logic [NUM_CH-1:0] fault_r,   fault_nxt;
    logic [NUM_CH-1:0] req_r,     req_nxt;
    logic [NUM_CH-1:0] ign_r,     ign_nxt;
    logic [TMR_W-1:0]  step_r,    step_nxt;
    logic [8:0]        pcnt_r,    pcnt_nxt;
    logic [15:0]       rdata_r,   rdata_nxt;
    logic              rvalid_r,  rvalid_nxt;
    logic [NUM_PWM-1:0] pwm_r,    pwm_nxt;
    logic [NUM_PWM-1:0] oe_n_r,   oe_n_nxt;
    smc_dac_drive_t    dac_r      [NUM_DAC];
    smc_dac_drive_t    dac_nxt    [NUM_DAC];
    logic              tick;
    logic              cfg_hit;

    assign tick    = (step_r == TMR_W'(STEP_CYCLES - 1));
    assign cfg_hit = (CMD_CODE == CMD_MARGIN_CONFIG) && (CMD_PAGE < 4'(NUM_CH));

    always_comb begin
        logic              req;
        logic [VOUT_W-1:0] avg;
        logic              want_up;
        logic              want_dn;
        logic              inc;
        logic              is_dac;
        logic [15:0]       wv;
        req = 1'b0;
        avg = '0;
        want_up = 1'b0;
        want_dn = 1'b0;
        inc = 1'b0;
        is_dac = 1'b0;
        wv = '0;
        // R16: 20ms averaging window
        step_nxt = tick ? '0 : step_r + 1'b1;
        // R18: 312.5kHz pwm period
        pcnt_nxt = (pcnt_r == 9'(PWM_PERIOD_CYC - 1)) ? '0 : pcnt_r + 1'b1;
        rvalid_nxt = CMD_RD;
        rdata_nxt = rdata_r;
        if (CMD_RD) begin
            // R3: reserved bits read zero
            rdata_nxt = cfg_hit ? (16'(cfg_r[CMD_PAGE]) & CFG_RW_MASK) : 16'h0000;
        end
        for (int c = 0; c < NUM_CH; c++) begin
            is_dac = (c >= NUM_PWM);
            cfg_nxt[c] = cfg_r[c];
            if (CMD_WR && cfg_hit && (CMD_PAGE == 4'(c))) begin
                wv = CMD_WDATA & CFG_RW_MASK;
                cfg_nxt[c] = smc_cfg_t'(wv);
                // R12: dac pages forced to zero level
                if (is_dac) begin
                    cfg_nxt[c].initial_drive_level = DAC_AUTO_LEVEL;
                end
            end
            req = MARGIN_HIGH[c] | MARGIN_LOW[c];
            req_nxt[c] = req;
            ign_nxt[c] = IGNORE_FAULTS[c];
            // R6: settle window after margin-off under ignore-faults
            settle_nxt[c] = (settle_r[c] != '0) ? settle_r[c] - 1'b1 : '0;
            if (req_r[c] && !req && ign_r[c]) begin
                settle_nxt[c] = TMR_W'(SETTLE_CYCLES);
            end
            active_nxt[c] = active_r[c];
            set_nxt[c] = set_r[c];
            sum_nxt[c] = sum_r[c];
            cnt_nxt[c] = cnt_r[c];
            first_nxt[c] = first_r[c];
            // R10: sticky fault, a new event beats the clear
            fault_nxt[c] = CLEAR_FAULTS ? 1'b0 : fault_r[c];
            if (!req) begin
                active_nxt[c] = 1'b0;
            end else if (!active_r[c] && PG_ALL) begin
                // R15: start only once all rails are power good
                active_nxt[c] = 1'b1;
                // R4: begin from initial drive level
                set_nxt[c] = cfg_r[c].initial_drive_level;
                sum_nxt[c] = '0;
                cnt_nxt[c] = '0;
                first_nxt[c] = 1'b1;
            end else if (active_r[c] && cfg_r[c].fixed_level) begin
                // R2: fixed level held constant
                set_nxt[c] = cfg_r[c].initial_drive_level;
            end else if (active_r[c]) begin
                if (ADC_VALID && ADC_CH == 4'(c) && cnt_r[c] < 3'(AVG_SAMPLES)) begin
                    sum_nxt[c] = sum_r[c] + SUM_W'(ADC_DATA);
                    cnt_nxt[c] = cnt_r[c] + 1'b1;
                end
                if (tick) begin
                    sum_nxt[c] = '0;
                    cnt_nxt[c] = '0;
                end
                if (tick && cnt_r[c] == 3'(AVG_SAMPLES)) begin
                    avg = sum_r[c][SUM_W-1:AVG_SHIFT];
                    want_up = avg < VOUT_TARGET[c];
                    want_dn = avg > VOUT_TARGET[c];
                    first_nxt[c] = 1'b0;
                    // R7: first step already past target
                    if (first_r[c] && ((MARGIN_HIGH[c] && want_dn) ||
                                       (MARGIN_LOW[c] && want_up))) begin
                        fault_nxt[c] = 1'b1;
                    end
                    // R1: slope picks the step direction on dac pages only
                    inc = (want_up == inc_raises(cfg_r[c].slope, is_dac));
                    // R9: loop keeps stepping after a fault
                    if (want_up || want_dn) begin
                        if (inc && set_r[c] == LEVEL_MAX) begin
                            // R8 R11: full scale short of target
                            fault_nxt[c] = 1'b1;
                        end else if (!inc && set_r[c] == LEVEL_MIN) begin
                            // R8: zero short of target
                            fault_nxt[c] = 1'b1;
                        end else begin
                            // R19: saturating single step
                            set_nxt[c] = inc ? set_r[c] + 1'b1 : set_r[c] - 1'b1;
                        end
                    end
                end
            end
        end
        for (int p = 0; p < NUM_PWM; p++) begin
            pwm_nxt[p] = active_r[p] && (pcnt_r < duty_thresh(set_r[p]));
            // R17: pwm released when idle
            oe_n_nxt[p] = !active_r[p];
        end
        for (int d = 0; d < NUM_DAC; d++) begin
            // R5: page 8 plus d drives dac output d
            dac_nxt[d].enable = active_r[NUM_PWM + d];
            // R14: low margin sources, high margin sinks
            dac_nxt[d].source = MARGIN_LOW[NUM_PWM + d];
            dac_nxt[d].level = active_r[NUM_PWM + d] ? set_r[NUM_PWM + d] : 8'h00;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cfg_r[c] <= smc_cfg_t'(CFG_RESET);
                set_r[c] <= '0;
                sum_r[c] <= '0;
                cnt_r[c] <= '0;
                settle_r[c] <= '0;
            end
            for (int d = 0; d < NUM_DAC; d++) begin
                dac_r[d] <= '0;
            end
            active_r <= '0;
            first_r <= '0;
            fault_r <= '0;
            req_r <= '0;
            ign_r <= '0;
            step_r <= '0;
            pcnt_r <= '0;
            rdata_r <= '0;
            rvalid_r <= 1'b0;
            pwm_r <= '0;
            oe_n_r <= '1;
        end else begin
            cfg_r <= cfg_nxt;
            set_r <= set_nxt;
            sum_r <= sum_nxt;
            cnt_r <= cnt_nxt;
            settle_r <= settle_nxt;
            dac_r <= dac_nxt;
            active_r <= active_nxt;
            first_r <= first_nxt;
            fault_r <= fault_nxt;
            req_r <= req_nxt;
            ign_r <= ign_nxt;
            step_r <= step_nxt;
            pcnt_r <= pcnt_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            pwm_r <= pwm_nxt;
            oe_n_r <= oe_n_nxt;
        end
    end

    assign CMD_RDATA = rdata_r;
    assign CMD_RVALID = rvalid_r;
    assign TRIM_PWM_OUT = pwm_r;
    assign TRIM_PWM_OE_N = oe_n_r;
    assign CURRENT_DAC_OUT = dac_r;
    assign MARGIN_FAULT = fault_r;
    // R10: summary flag and gated alert
    assign STATUS_MARGIN = |fault_r;
    assign ALERT = ALERT_EN && (|fault_r);
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            FAULT_MON_INHIBIT[c] = (settle_r[c] != '0);
        end
    end
endmodule
`default_nettype wire

// [verification/smc_supply_model.sv]
// supply side model: vout samples for every channel, round robin
// assumes the bench sets one vout level and enables the sampler
`timescale 1ns/1ps
`default_nettype none
module smc_supply_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        en,
    input  wire logic [15:0] vout,
    output logic             adc_valid,
    output logic [3:0]       adc_ch,
    output logic [15:0]      adc_data
);
    always_ff @(posedge clk) begin
        if (rst) begin
            adc_valid <= 1'b0;
            adc_ch    <= 4'h0;
            adc_data  <= 16'h5a5a;
        end else if (!en) begin
            adc_valid <= 1'b0;
            // idle bus toggles so no stale sample looks valid
            adc_data  <= ~adc_data;
        end else begin
            adc_valid <= 1'b1;
            adc_data  <= vout;
            adc_ch    <= (adc_ch >= 4'hb) ? 4'h0 : adc_ch + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [verification/smc_margin_monitor.sv]
// checker on the margin controller ports
// assumes a bind from the bench top, single MCLK domain
`timescale 1ns/1ps
`default_nettype none
module smc_margin_monitor
    import smc_pkg::*;
(
    input wire logic                 MCLK,
    input wire logic                 RESET,
    input wire logic [3:0]           CMD_PAGE,
    input wire logic [15:0]          CMD_RDATA,
    input wire logic                 CMD_RVALID,
    input wire logic [NUM_CH-1:0]    MARGIN_HIGH,
    input wire logic [NUM_CH-1:0]    MARGIN_LOW,
    input wire logic [NUM_CH-1:0]    IGNORE_FAULTS,
    input wire logic                 PG_ALL,
    input wire logic                 ALERT_EN,
    input wire logic                 CLEAR_FAULTS,
    input wire logic [NUM_PWM-1:0]   TRIM_PWM_OE_N,
    input wire smc_dac_drive_t       CURRENT_DAC_OUT [NUM_DAC],
    input wire logic [NUM_CH-1:0]    MARGIN_FAULT,
    input wire logic                 STATUS_MARGIN,
    input wire logic                 ALERT,
    input wire logic [NUM_CH-1:0]    FAULT_MON_INHIBIT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    chk_rsvd_zero: assert property (CMD_RVALID |-> CMD_RDATA[13:8] == 6'h00)
        else $error("reserved config bits read nonzero");
    chk_dac_level_zero: assert property (CMD_RVALID && $past(CMD_PAGE) >= 4'h8
        && $past(CMD_PAGE) <= 4'hb |-> CMD_RDATA[7:0] == 8'h00)
        else $error("dac page drive level not zero");
    chk_pwm_idle_hiz: assert property (!(MARGIN_HIGH[0] | MARGIN_LOW[0]) [*3]
        |-> TRIM_PWM_OE_N[0]) else $error("pwm driven while idle");
    chk_dac_idle_hiz: assert property (!(MARGIN_HIGH[8] | MARGIN_LOW[8]) [*3]
        |-> !CURRENT_DAC_OUT[0].enable) else $error("dac driven while idle");
    chk_start_pg: assert property ($fell(TRIM_PWM_OE_N[0]) |-> $past(PG_ALL, 2)
        && $past(MARGIN_HIGH[0] | MARGIN_LOW[0], 2)) else $error("margin began early");
    chk_settle_window: assert property ($fell(MARGIN_HIGH[0]) && !MARGIN_LOW[0]
        && $past(IGNORE_FAULTS[0]) |-> ##[1:3] FAULT_MON_INHIBIT[0] [*8])
        else $error("settle inhibit missing");
    chk_no_wrap: assert property (CURRENT_DAC_OUT[0].enable
        && $past(CURRENT_DAC_OUT[0].enable) && $past(CURRENT_DAC_OUT[0].level) == 8'hff
        |-> CURRENT_DAC_OUT[0].level != 8'h00) else $error("dac level wrapped");
    chk_fault_sticky: assert property (|($past(MARGIN_FAULT) & ~MARGIN_FAULT)
        |-> $past(CLEAR_FAULTS)) else $error("fault flag dropped without clear");
    chk_status_or: assert property (STATUS_MARGIN == (|MARGIN_FAULT))
        else $error("summary flag differs from page flags");
    chk_alert_gate: assert property (ALERT == (ALERT_EN && STATUS_MARGIN))
        else $error("alert differs from enabled summary");
    chk_dac_source: assert property (CURRENT_DAC_OUT[0].enable
        && $past(MARGIN_LOW[8]) == MARGIN_LOW[8] && $past(MARGIN_LOW[8], 2) == MARGIN_LOW[8]
        |-> CURRENT_DAC_OUT[0].source == MARGIN_LOW[8]) else $error("dac direction wrong");
    cov_first_fault: cover property (MARGIN_FAULT[9]);
    cov_pwm_start: cover property ($fell(TRIM_PWM_OE_N[0]));
    cov_settle: cover property (FAULT_MON_INHIBIT[0]);
endmodule
`default_nettype wire

// [verification/test_supply_margin_controller.sv]
// bench for the margin controller: config access and margin runs
// assumes short step and settle counts handed in as parameters
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("FAIL %s exp %0h got %0h", n, e, a); end end
module test_supply_margin_controller;
    import smc_pkg::*;
    localparam int  SETTLE = 32;
    int             err_count = 0;
    int             compares = 0;
    logic           MCLK = 1'b0;
    logic           RESET = 1'b1;
    logic           CMD_WR = 1'b0;
    logic           CMD_RD = 1'b0;
    logic [3:0]     CMD_PAGE = 4'h0;
    logic [7:0]     CMD_CODE = CMD_MARGIN_CONFIG;
    logic [15:0]    CMD_WDATA = 16'h0000;
    logic [15:0]    CMD_RDATA;
    logic           CMD_RVALID;
    logic [11:0]    MARGIN_HIGH = 12'h000;
    logic [11:0]    MARGIN_LOW = 12'h000;
    logic [11:0]    IGNORE_FAULTS = 12'h000;
    logic           PG_ALL = 1'b0;
    logic [15:0]    VOUT_TARGET [NUM_CH] = '{default: 16'h1000};
    logic           ADC_VALID;
    logic [3:0]     ADC_CH;
    logic [15:0]    ADC_DATA;
    logic           ALERT_EN = 1'b0;
    logic           CLEAR_FAULTS = 1'b0;
    logic [7:0]     TRIM_PWM_OUT;
    logic [7:0]     TRIM_PWM_OE_N;
    smc_dac_drive_t CURRENT_DAC_OUT [NUM_DAC];
    logic [11:0]    MARGIN_FAULT;
    logic           STATUS_MARGIN;
    logic           ALERT;
    logic [11:0]    FAULT_MON_INHIBIT;
    logic           model_en = 1'b1;
    always #5 MCLK = ~MCLK;
    smc_margin_ctrl #(.STEP_CYCLES(64), .SETTLE_CYCLES(SETTLE)) u_dut (.MCLK(MCLK),
        .RESET(RESET), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD), .CMD_PAGE(CMD_PAGE),
        .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
        .CMD_RVALID(CMD_RVALID), .MARGIN_HIGH(MARGIN_HIGH), .MARGIN_LOW(MARGIN_LOW),
        .IGNORE_FAULTS(IGNORE_FAULTS), .PG_ALL(PG_ALL), .VOUT_TARGET(VOUT_TARGET),
        .ADC_VALID(ADC_VALID), .ADC_CH(ADC_CH), .ADC_DATA(ADC_DATA), .ALERT_EN(ALERT_EN),
        .CLEAR_FAULTS(CLEAR_FAULTS), .TRIM_PWM_OUT(TRIM_PWM_OUT), .TRIM_PWM_OE_N(TRIM_PWM_OE_N),
        .CURRENT_DAC_OUT(CURRENT_DAC_OUT), .MARGIN_FAULT(MARGIN_FAULT),
        .STATUS_MARGIN(STATUS_MARGIN), .ALERT(ALERT), .FAULT_MON_INHIBIT(FAULT_MON_INHIBIT));
    smc_supply_model u_supply (.clk(MCLK), .rst(RESET), .en(model_en), .vout(16'h2000),
        .adc_valid(ADC_VALID), .adc_ch(ADC_CH), .adc_data(ADC_DATA));
    task automatic summarize();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic guard(input int i, input int n);
        if (i >= n) begin
            err_count++;
            summarize();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic wr(input logic [3:0] p, input logic [15:0] d);
        CMD_PAGE = p;
        CMD_CODE = CMD_MARGIN_CONFIG;
        CMD_WDATA = d;
        CMD_WR = 1'b1;
        cyc(1);
        CMD_WR = 1'b0;
    endtask
    task automatic rd(input logic [3:0] p, input logic [7:0] c, input logic [15:0] e);
        CMD_PAGE = p;
        CMD_CODE = c;
        CMD_RD = 1'b1;
        cyc(1);
        CMD_RD = 1'b0;
        `CHK("rvalid", 1'b1, CMD_RVALID)
        `CHK("rdata", e, CMD_RDATA)
        // let an edge pass so a following read never re-raises the strobe in one step
        cyc(1);
    endtask
    initial begin
        int i;
        int hi;
        cyc(5);
        RESET = 1'b0;
        rd(4'h0, CMD_MARGIN_CONFIG, CFG_RESET);
        wr(4'h3, 16'hffff);
        rd(4'h3, CMD_MARGIN_CONFIG, 16'hc0ff);
        wr(4'h9, 16'h3fff);
        rd(4'h9, CMD_MARGIN_CONFIG, 16'h0000);
        rd(4'h3, 8'hd0, 16'h0000);
        wr(4'h0, 16'h4080);
        rd(4'h0, CMD_MARGIN_CONFIG, 16'h4080);
        MARGIN_HIGH[0] = 1'b1;
        IGNORE_FAULTS[0] = 1'b1;
        cyc(10);
        `CHK("oe_wait_pg", 1'b1, TRIM_PWM_OE_N[0])
        PG_ALL = 1'b1;
        cyc(3);
        `CHK("oe_on", 1'b0, TRIM_PWM_OE_N[0])
        hi = 0;
        for (i = 0; i < 320; i++) begin
            cyc(1);
            hi += (TRIM_PWM_OUT[0] === 1'b1);
        end
        `CHK("pwm_duty", 160, hi)
        MARGIN_HIGH[0] = 1'b0;
        cyc(4);
        `CHK("inhibit_on", 1'b1, FAULT_MON_INHIBIT[0])
        `CHK("oe_off", 1'b1, TRIM_PWM_OE_N[0])
        cyc(SETTLE + 4);
        `CHK("inhibit_end", 1'b0, FAULT_MON_INHIBIT[0])
        `CHK("fixed_no_fault", 12'h000, MARGIN_FAULT)
        ALERT_EN = 1'b1;
        MARGIN_LOW[8] = 1'b1;
        MARGIN_HIGH[9] = 1'b1;
        cyc(3);
        `CHK("dac8_on", 1'b1, CURRENT_DAC_OUT[0].enable)
        `CHK("dac8_src", 1'b1, CURRENT_DAC_OUT[0].source)
        `CHK("dac9_sink", 1'b0, CURRENT_DAC_OUT[1].source)
        `CHK("dac8_lvl", 8'h00, CURRENT_DAC_OUT[0].level)
        `CHK("dac2_off", 1'b0, CURRENT_DAC_OUT[2].enable)
        for (i = 0; i < 400 && MARGIN_FAULT[9] !== 1'b1; i++) cyc(1);
        guard(i, 400);
        `CHK("first_fault", 12'h200, MARGIN_FAULT)
        `CHK("status", 1'b1, STATUS_MARGIN)
        `CHK("alert", 1'b1, ALERT)
        // the dac output follows the stepped setting one edge after the fault flag
        cyc(1);
        `CHK("dac8_step", 8'h01, CURRENT_DAC_OUT[0].level)
        `CHK("dac9_on", 1'b1, CURRENT_DAC_OUT[1].enable)
        ALERT_EN = 1'b0;
        MARGIN_HIGH[9] = 1'b0;
        CLEAR_FAULTS = 1'b1;
        cyc(1);
        `CHK("alert_masked", 1'b0, ALERT)
        CLEAR_FAULTS = 1'b0;
        cyc(1);
        `CHK("cleared", 12'h000, MARGIN_FAULT)
        // positive slope, margin low, voltage too high: setting starts at zero and hits the zero limit
        wr(4'ha, 16'h8000);
        MARGIN_LOW[10] = 1'b1;
        for (i = 0; i < 20000 && MARGIN_FAULT[8] !== 1'b1; i++) cyc(1);
        guard(i, 20000);
        `CHK("full_scale", 8'hff, CURRENT_DAC_OUT[0].level)
        `CHK("zero_limit", 1'b1, MARGIN_FAULT[10])
        `CHK("dac10_lvl", 8'h00, CURRENT_DAC_OUT[2].level)
        `CHK("dac10_on", 1'b1, CURRENT_DAC_OUT[2].enable)
        cyc(200);
        `CHK("saturate", 8'hff, CURRENT_DAC_OUT[0].level)
        `CHK("keeps_on", 1'b1, CURRENT_DAC_OUT[0].enable)
        summarize();
    end
endmodule
bind smc_margin_ctrl smc_margin_monitor u_mon (.MCLK(MCLK), .RESET(RESET),
    .CMD_PAGE(CMD_PAGE), .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID),
    .MARGIN_HIGH(MARGIN_HIGH), .MARGIN_LOW(MARGIN_LOW), .IGNORE_FAULTS(IGNORE_FAULTS),
    .PG_ALL(PG_ALL), .ALERT_EN(ALERT_EN), .CLEAR_FAULTS(CLEAR_FAULTS),
    .TRIM_PWM_OE_N(TRIM_PWM_OE_N), .CURRENT_DAC_OUT(CURRENT_DAC_OUT),
    .MARGIN_FAULT(MARGIN_FAULT), .STATUS_MARGIN(STATUS_MARGIN), .ALERT(ALERT),
    .FAULT_MON_INHIBIT(FAULT_MON_INHIBIT));
`default_nettype wire
